// file: hw/ais_adc_ctrl.sv
// Converter input selection, result capture and APB register file.
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`include "ais_consts.svh"
module ais_adc_ctrl
	import ais_pkg::*;
(
	input wire logic mclk, // System clock, 250 MHz.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic ce, // Clock enable; all state holds while low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [11:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped addresses.
	input wire logic convStart, // Conversion engine starts a conversion.
	input wire logic convDone, // Conversion engine finished, result valid.
	input wire logic [9:0] convCode, // Raw magnitude from the converter.
	input wire logic convBelow, // Positive input was not above negative.
	input wire logic convOver, // Difference reached reference over gain.
	output ais_chan_type muxPos, // Positive or single-ended input select.
	output ais_chan_type muxNeg, // Negative input select.
	output logic diffEn, // Differential gain path in use.
	output logic gain20, // Gain stage set to 20x.
	output logic bandgapSel, // Bandgap connected as input.
	output logic groundSel, // Ground connected as input.
	output logic refSupplyEn, // Analog supply used as reference.
	output logic refPinEn, // External reference pin used.
	output logic refIntEn, // Internal reference powered.
	output logic refPinLink, // Internal reference tied to the pin.
	output logic irq // Level interrupt, unmasked done flag.
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] sel_r;
	logic [7:0] activeSel_r;
	logic busy_r;
	logic [9:0] result_r;
	logic doneFlag_r;
	logic mask_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic irq_r;
	ais_chan_type muxPos_r, muxNeg_r;
	logic diffEn_r, gain20_r, bandgapSel_r, groundSel_r;
	logic refSupplyEn_r, refPinEn_r, refIntEn_r, refPinLink_r;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// One wait state: pready rises in the second access cycle, so data comes from a flop.
	wire logic [7:0] regIdx = paddr[9:2];
	wire logic accessCyc = psel & penable & ~pready_r;
	wire logic commit = psel & penable & pready_r;
	wire logic hitLow = regIdx == `AIS_IDX_RES_LOW;
	wire logic hitHigh = regIdx == `AIS_IDX_RES_HIGH;
	wire logic hitSel = regIdx == `AIS_IDX_SEL;
	wire logic hitStatus = regIdx == `AIS_IDX_STATUS;
	wire logic hitMask = regIdx == `AIS_IDX_MASK;
	wire logic mapped = (hitLow | hitHigh | hitSel | hitStatus | hitMask) & (paddr[11:10] == 2'h0);
	wire logic wrSel = commit & pwrite & hitSel & mapped;
	wire logic wrStatus = commit & pwrite & hitStatus & mapped;
	wire logic wrMask = commit & pwrite & hitMask & mapped;

	// ----------------------------------------------------------------
	// Result presentation
	// ----------------------------------------------------------------
	// Alignment reads the live register bit, so a write shows at once.
	wire logic alignLeft = sel_r[`AIS_SEL_ALIGN];
	wire logic [7:0] lowByte = alignLeft ? {result_r[1:0], 6'h00} : result_r[7:0];
	wire logic [7:0] highByte = alignLeft ? result_r[9:2] : {6'h00, result_r[9:8]};
	wire logic [7:0] statusByte = {6'h00, busy_r, doneFlag_r};
	wire logic [7:0] readByte = hitLow ? lowByte : hitHigh ? highByte : hitSel ? sel_r :
		hitStatus ? statusByte : {7'h00, mask_r};

	// ----------------------------------------------------------------
	// Result encoding
	// ----------------------------------------------------------------
	// The analog side reports magnitude and range; saturation is settled here.
	wire logic activeDiff = activeSel_r[`AIS_SEL_CODE_HI:0] > `AIS_LAST_SINGLE &&
		activeSel_r[`AIS_SEL_CODE_HI:0] < `AIS_CODE_BANDGAP;
	wire logic [9:0] encoded = (activeDiff && convBelow) ? `AIS_CODE_ZERO :
		(activeDiff && convOver) ? `AIS_CODE_FULL : convCode;

	// ----------------------------------------------------------------
	// Decoders
	// ----------------------------------------------------------------
	ais_chan_type decPos, decNeg;
	logic decDiff, decGain, decBg, decGnd;
	ais_decode u_decode (
		.code(activeSel_r[`AIS_SEL_CODE_HI:0]),
		.posSel(decPos),
		.negSel(decNeg),
		.diffEn(decDiff),
		.gain20(decGain),
		.bandgapSel(decBg),
		.groundSel(decGnd)
	);
	wire ais_ref_type refSel = ais_ref_type'(activeSel_r[`AIS_SEL_REF_HI:`AIS_SEL_REF_LO]);
	wire logic busy_nxt = convStart | (busy_r & ~convDone);
	wire logic doneFlag_nxt = convDone | (doneFlag_r & ~(wrStatus & pwdata[`AIS_ST_DONE]));

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	// All bits of the select register are software read/write.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sel_r <= `AIS_SEL_RESET;
			mask_r <= 1'b0;
		end else if (ce) begin
			if (wrSel) sel_r <= pwdata[7:0];
			if (wrMask) mask_r <= pwdata[0];
		end
	end

	// APB answer: one wait cycle, read data and error captured with pready.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (ce) begin
			pready_r <= accessCyc;
			pslverr_r <= accessCyc & ~mapped;
			if (accessCyc) prdata_r <= (mapped && !pwrite) ? {24'h00_0000, readByte} : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Conversion tracking
	// ----------------------------------------------------------------
	// Settings follow the register only while idle, so a running conversion is never disturbed.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			activeSel_r <= `AIS_SEL_RESET;
			busy_r <= 1'b0;
		end else if (ce) begin
			if (!busy_r) activeSel_r <= sel_r;
			busy_r <= busy_nxt;
		end
	end

	// Result and done flag move together; a new completion beats a clear.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			result_r <= `AIS_CODE_ZERO;
			doneFlag_r <= 1'b0;
			irq_r <= 1'b0;
		end else if (ce) begin
			if (convDone) result_r <= encoded;
			doneFlag_r <= doneFlag_nxt;
			irq_r <= doneFlag_nxt & mask_r;
		end
	end

	// ----------------------------------------------------------------
	// Analog controls
	// ----------------------------------------------------------------
	// Registered so the switches never see decoder glitches.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			muxPos_r <= 4'h0;
			muxNeg_r <= 4'h0;
			{diffEn_r, gain20_r, bandgapSel_r, groundSel_r} <= 4'h0;
			{refSupplyEn_r, refPinEn_r, refIntEn_r, refPinLink_r} <= 4'h8;
		end else if (ce) begin
			muxPos_r <= decPos;
			muxNeg_r <= decNeg;
			{diffEn_r, gain20_r, bandgapSel_r, groundSel_r} <= {decDiff, decGain, decBg, decGnd};
			refSupplyEn_r <= refSel == AIS_REF_SUPPLY;
			refPinEn_r <= refSel == AIS_REF_PIN;
			refIntEn_r <= refSel == AIS_REF_INTERNAL || refSel == AIS_REF_DECOUPLED;
			refPinLink_r <= refSel == AIS_REF_DECOUPLED;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;
	assign muxPos = muxPos_r;
	assign muxNeg = muxNeg_r;
	assign diffEn = diffEn_r;
	assign gain20 = gain20_r;
	assign bandgapSel = bandgapSel_r;
	assign groundSel = groundSel_r;
	assign refSupplyEn = refSupplyEn_r;
	assign refPinEn = refPinEn_r;
	assign refIntEn = refIntEn_r;
	assign refPinLink = refPinLink_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence doneSeen;
		ce && convDone;
	endsequence
	sequence readLowReq;
		ce && accessCyc && !pwrite && hitLow && (paddr[11:10] == 2'h0);
	endsequence
	sequence readHighReq;
		ce && accessCyc && !pwrite && hitHigh && (paddr[11:10] == 2'h0);
	endsequence

	done_with_result_a: assert property (doneSeen |=> doneFlag_r && result_r == $past(encoded))
		else $error("Result and done flag did not update together.");
	result_held_a: assert property (ce && !convDone |=> $stable(result_r))
		else $error("Result changed without a completion.");
	single_code_a: assert property (doneSeen and !activeDiff |=> result_r == $past(convCode))
		else $error("Single-ended result not the converter code.");
	diff_clamp_a: assert property (doneSeen and activeDiff && convBelow |=> result_r == 10'h000)
		else $error("Negative difference did not clamp to zero.");
	diff_full_a: assert property (doneSeen and activeDiff && !convBelow && convOver
		|=> result_r == 10'h3FF)
		else $error("Full difference did not read full scale.");
	settings_frozen_a: assert property (busy_r |=> $stable(activeSel_r))
		else $error("Active settings changed during a conversion.");
	change_waits_a: assert property (ce && busy_r && !convDone && wrSel |=> busy_r ##1 activeSel_r == $past(activeSel_r, 2))
		else $error("New settings applied before completion.");
	sel_write_a: assert property (ce && wrSel |=> sel_r == $past(pwdata[7:0]))
		else $error("Select register did not take the written value.");
	low_align_a: assert property (readLowReq |=> prdata[7:0] == ($past(alignLeft) ?
		{$past(result_r[1:0]), 6'h00} : $past(result_r[7:0])))
		else $error("Low result byte wrongly aligned.");
	single_route_a: assert property (ce && activeSel_r[4:0] <= 5'h0A |=> !diffEn && muxPos == $past(activeSel_r[3:0]))
		else $error("Single-ended code not routed.");
	offset_pair_a: assert property (ce && activeSel_r[4:0] == 5'h16 |=> muxPos == 4'h5 && muxNeg == 4'h5 && gain20)
		else $error("Offset code did not short the pin at 20x.");
	ground_pick_a: assert property (ce && activeSel_r[4:0] == 5'h1F |=> groundSel && !diffEn && !bandgapSel)
		else $error("Ground code did not select ground.");
	int_ref_a: assert property (ce && activeSel_r[7:6] == 2'b10 |=> refIntEn && !refPinLink && !refSupplyEn)
		else $error("Internal reference select wrong.");

	// Remaining reference codes; only one source may ever drive the reference node.
	ref_supply_a: assert property (ce && activeSel_r[7:6] == 2'b00 |=> refSupplyEn && !refPinEn && !refIntEn)
		else $error("Supply reference select wrong.");
	ref_pin_a: assert property (ce && activeSel_r[7:6] == 2'b01 |=> refPinEn && !refIntEn && !refSupplyEn)
		else $error("Pin reference select wrong.");
	ref_decoupled_a: assert property (ce && activeSel_r[7:6] == 2'b11 |=> refIntEn && refPinLink && !refPinEn)
		else $error("Decoupled reference select wrong.");

	// Bandgap and a plain pair route; a wrong table row would slip past the offset check.
	bandgap_pick_a: assert property (ce && activeSel_r[4:0] == 5'h1E |=> bandgapSel && !groundSel && !diffEn)
		else $error("Bandgap code did not select the bandgap.");
	diff_route_a: assert property (ce && activeSel_r[4:0] == 5'h0B |=> muxPos == 4'h0 && muxNeg == 4'h1 && diffEn && gain20)
		else $error("First pair code routed wrongly.");

	// High byte follows the live alignment bit at the time of the read.
	high_align_a: assert property (readHighReq |=> prdata[7:0] == ($past(alignLeft) ?
		$past(result_r[9:2]) : {6'h00, $past(result_r[9:8])}))
		else $error("High result byte wrongly aligned.");
endmodule

// file: hw/ais_consts.svh
// Offsets, field positions and reset values of the converter input-select block.
`ifndef AIS_CONSTS_SVH
`define AIS_CONSTS_SVH
// Register indices; the APB byte address is four times the index.
`define AIS_IDX_RES_LOW 8'h04
`define AIS_IDX_RES_HIGH 8'h05
`define AIS_IDX_SEL 8'h07
`define AIS_IDX_STATUS 8'h08
`define AIS_IDX_MASK 8'h09
// Input-select register fields.
`define AIS_SEL_REF_HI 7
`define AIS_SEL_REF_LO 6
`define AIS_SEL_ALIGN 5
`define AIS_SEL_CODE_HI 4
`define AIS_SEL_RESET 8'h00
// Status fields: done flag is write-one-to-clear, busy is read only.
`define AIS_ST_DONE 0
`define AIS_ST_BUSY 1
`define AIS_MASK_RESET 8'h00
// Result codes, the last single-ended channel code and the bandgap and ground channel codes.
`define AIS_CODE_ZERO 10'h000
`define AIS_CODE_FULL 10'h3FF
`define AIS_LAST_SINGLE 5'h0A
`define AIS_CODE_BANDGAP 5'h1E
`define AIS_CODE_GROUND 5'h1F
`endif

// file: hw/ais_decode.sv
// Channel and gain code decoder for the analog input multiplexer.
`timescale 1ns/100ps
`include "ais_consts.svh"
module ais_decode
	import ais_pkg::*;
(
	input wire logic [4:0] code, // Channel and gain code.
	output ais_chan_type posSel, // Positive or single-ended input.
	output ais_chan_type negSel, // Negative input.
	output logic diffEn, // Differential path in use.
	output logic gain20, // Gain stage at 20x.
	output logic bandgapSel, // Bandgap as single-ended input.
	output logic groundSel // Ground as single-ended input.
);
	// ----------------------------------------------------------------
	// Table decode
	// ----------------------------------------------------------------
	// Single-ended codes bypass the gain stage; the rest follow the pair table.
	always_comb begin
		posSel = 4'h0;
		negSel = 4'h0;
		diffEn = 1'b0;
		gain20 = 1'b0;
		bandgapSel = 1'b0;
		groundSel = 1'b0;
		if (code <= `AIS_LAST_SINGLE) begin
			posSel = code[3:0];
		end else begin
			diffEn = 1'b1;
			unique case (code)
				5'h0B: begin posSel = 4'h0; negSel = 4'h1; gain20 = 1'b1; end
				5'h0C: begin posSel = 4'h0; negSel = 4'h1; end
				5'h0D: begin posSel = 4'h1; negSel = 4'h1; gain20 = 1'b1; end
				5'h0E: begin posSel = 4'h2; negSel = 4'h1; gain20 = 1'b1; end
				5'h0F: begin posSel = 4'h2; negSel = 4'h1; end
				5'h10: begin posSel = 4'h2; negSel = 4'h3; end
				5'h11: begin posSel = 4'h3; negSel = 4'h3; gain20 = 1'b1; end
				5'h12: begin posSel = 4'h4; negSel = 4'h3; gain20 = 1'b1; end
				5'h13: begin posSel = 4'h4; negSel = 4'h3; end
				5'h14: begin posSel = 4'h4; negSel = 4'h5; gain20 = 1'b1; end
				5'h15: begin posSel = 4'h4; negSel = 4'h5; end
				5'h16: begin posSel = 4'h5; negSel = 4'h5; gain20 = 1'b1; end
				5'h17: begin posSel = 4'h6; negSel = 4'h5; gain20 = 1'b1; end
				5'h18: begin posSel = 4'h6; negSel = 4'h5; end
				5'h19: begin posSel = 4'h8; negSel = 4'h9; gain20 = 1'b1; end
				5'h1A: begin posSel = 4'h8; negSel = 4'h9; end
				5'h1B: begin posSel = 4'h9; negSel = 4'h9; gain20 = 1'b1; end
				5'h1C: begin posSel = 4'hA; negSel = 4'h9; gain20 = 1'b1; end
				5'h1D: begin posSel = 4'hA; negSel = 4'h9; end
				`AIS_CODE_BANDGAP: begin diffEn = 1'b0; bandgapSel = 1'b1; end
				`AIS_CODE_GROUND: begin diffEn = 1'b0; groundSel = 1'b1; end
				default: diffEn = 1'b0;
			endcase
		end
	end
endmodule

// file: hw/ais_pkg.sv
// Types shared by the converter input-select block.
package ais_pkg;
	// Reference choices in the order of their two-bit select code.
	typedef enum logic [1:0] {
		AIS_REF_SUPPLY,
		AIS_REF_PIN,
		AIS_REF_INTERNAL,
		AIS_REF_DECOUPLED
	} ais_ref_type;
	typedef logic [3:0] ais_chan_type;
endpackage

// file: testbench/ais_conv_model.sv
// Behavioural conversion engine that faces the input-select block.
`timescale 1ns/100ps
module ais_conv_model (
	input wire logic mclk, // System clock.
	output logic convStart, // Start pulse.
	output logic convDone, // Completion pulse.
	output logic [9:0] convCode, // Magnitude, valid with convDone only.
	output logic convBelow, // Positive input not above negative.
	output logic convOver // Difference at full scale.
);
	// Idle levels; the data lines carry no meaning outside the done pulse.
	initial begin
		convStart = 1'b0;
		convDone = 1'b0;
		convCode = 10'h000;
		convBelow = 1'b0;
		convOver = 1'b0;
	end
	// One conversion; dly sets how long the engine stays busy, so both quick
	// and slow answers can be exercised. Stale data is inverted after the
	// pulse, because a held value could pass for a fresh result.
	task automatic convert(input logic [9:0] c, input logic b, input logic o, input int dly);
		@(posedge mclk);
		convStart <= 1'b1;
		@(posedge mclk);
		convStart <= 1'b0;
		repeat (dly) @(posedge mclk);
		convCode <= c;
		convBelow <= b;
		convOver <= o;
		convDone <= 1'b1;
		@(posedge mclk);
		convDone <= 1'b0;
		convCode <= ~c;
		convBelow <= ~b;
		convOver <= ~o;
	endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the converter input-select block.
`timescale 1ns/100ps
`include "ais_consts.svh"
module tb_top
	import ais_pkg::*;
;
	logic mclk, rst_b, ce, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, lfsrState;
	logic convStart, convDone, convBelow, convOver, diffEn, gain20, bandgapSel, groundSel;
	logic refSupplyEn, refPinEn, refIntEn, refPinLink, irq;
	logic [9:0] convCode, resM;
	logic [4:0] cd;
	ais_chan_type muxPos, muxNeg;
	int failCount, numChecks;
	// Reference model: differential pair table for codes 11 to 29.
	logic [3:0] posT [19] = '{0, 0, 1, 2, 2, 2, 3, 4, 4, 4, 4, 5, 6, 6, 8, 8, 9, 10, 10};
	logic [3:0] negT [19] = '{1, 1, 1, 1, 1, 3, 3, 3, 3, 5, 5, 5, 5, 5, 9, 9, 9, 9, 9};
	logic [0:18] g20T = 19'b1011_0011_0101_1010_110;
	logic [3:0] refT [4] = '{4'h8, 4'h4, 4'h2, 4'h3};

	ais_adc_ctrl ais_adc_ctrl_i (.mclk, .rst_b, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .convStart, .convDone, .convCode, .convBelow, .convOver,
		.muxPos, .muxNeg, .diffEn, .gain20, .bandgapSel, .groundSel, .refSupplyEn, .refPinEn,
		.refIntEn, .refPinLink, .irq);
	ais_conv_model ais_conv_model_i (.mclk, .convStart, .convDone, .convCode, .convBelow,
		.convOver);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic endSim();
		$display("checks %0d mismatches %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			failCount++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Linear feedback shift register step for the random stimulus.
	function automatic logic [31:0] lfsrNext(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// One APB transfer; the idle edge first keeps back-to-back calls legal.
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			failCount++;
			endSim();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [31:0] x);
		apb(1'b0, idx, 32'h0000_0000);
		chk(q, x);
	endtask
	// Reads the result in both alignments; bit 5 of the select toggles and bits 7:6 are written as zero.
	task automatic chkRes(input logic [9:0] r, input logic [4:0] c);
		for (int a = 0; a < 2; a++) begin
			wr(`AIS_IDX_SEL, {26'h0, a[0], c});
			rdc(`AIS_IDX_RES_LOW, a ? {r[1:0], 6'h00} : r[7:0]);
			rdc(`AIS_IDX_RES_HIGH, a ? r[9:2] : {6'h00, r[9:8]});
		end
	endtask
	task automatic chkDec(input int c);
		int k;
		k = c - 11;
		if (c <= 10) begin
			chk(muxPos, c[3:0]);
			chk({diffEn, gain20, bandgapSel, groundSel}, 4'h0);
		end else if (c <= 29) begin
			chk({muxPos, muxNeg}, {posT[k], negT[k]});
			chk({diffEn, gain20}, {1'b1, g20T[k]});
		end else begin
			chk({diffEn, bandgapSel, groundSel}, {1'b0, c == 30, c == 31});
		end
	endtask

	// ----------------------------------------
	// Clock and main sequence
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// The clock enable is tied high; stalls are not exercised here.
	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		failCount = 0;
		numChecks = 0;
		lfsrState = 32'hf923_a730;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		rdc(`AIS_IDX_SEL, 32'h0000_0000);
		rdc(`AIS_IDX_RES_HIGH, 32'h0000_0000);
		chk({refSupplyEn, refPinEn, refIntEn, refPinLink}, 4'h8);
		for (int i = 0; i < 4; i++) begin
			lfsrState = lfsrNext(lfsrState);
			wr(`AIS_IDX_SEL, {24'h0, lfsrState[7:0]});
			rdc(`AIS_IDX_SEL, {24'h0, lfsrState[7:0]});
		end
		// Every channel code, with the reference code cycling alongside.
		for (int c = 0; c < 32; c++) begin
			wr(`AIS_IDX_SEL, {24'h0, c[1:0], 1'b0, c[4:0]});
			tick(3);
			chkDec(c);
			chk({refSupplyEn, refPinEn, refIntEn, refPinLink}, refT[c % 4]);
		end
		// Single-ended pass, differential clamp low, saturation and linear range.
		for (int i = 0; i < 4; i++) begin
			lfsrState = lfsrNext(lfsrState);
			cd = (i == 0) ? 5'd3 : 5'd20;
			wr(`AIS_IDX_SEL, {27'h0, cd});
			tick(3);
			ais_conv_model_i.convert(lfsrState[9:0], i == 1, i == 2, 5 + i * 10);
			resM = (i == 1) ? 10'h000 : (i == 2) ? 10'h3FF : lfsrState[9:0];
			rdc(`AIS_IDX_STATUS, 32'h0000_0001);
			chk(irq, 1'b0);
			chkRes(resM, cd);
			wr(`AIS_IDX_STATUS, 32'h0000_0001);
		end
		// Settings written mid-conversion wait until it completes.
		wr(`AIS_IDX_SEL, 32'h0000_000B);
		tick(3);
		fork
			ais_conv_model_i.convert(10'h2C5, 1'b0, 1'b0, 40);
			begin
				tick(6);
				wr(`AIS_IDX_SEL, 32'h0000_00E5);
				rdc(`AIS_IDX_SEL, 32'h0000_00E5);
				rdc(`AIS_IDX_STATUS, 32'h0000_0002);
				rdc(`AIS_IDX_RES_HIGH, {24'h0, resM[9:2]});
				tick(3);
				chk({muxPos, diffEn, gain20, refSupplyEn, refIntEn}, 8'h0E);
			end
		join
		tick(3);
		chk({muxPos, diffEn, refSupplyEn, refIntEn, refPinLink}, 8'h53);
		rdc(`AIS_IDX_RES_LOW, 32'h0000_0040);
		// The first result after a reference change is thrown away unchecked.
		ais_conv_model_i.convert(10'h155, 1'b0, 1'b0, 3);
		ais_conv_model_i.convert(10'h0A9, 1'b0, 1'b0, 3);
		chkRes(10'h0A9, 5'd5);
		// Interrupt: set while masked, unmask, clear; then junk accesses.
		chk(irq, 1'b0);
		wr(`AIS_IDX_MASK, 32'h0000_0001);
		tick(2);
		chk(irq, 1'b1);
		wr(`AIS_IDX_STATUS, 32'h0000_0001);
		tick(2);
		chk(irq, 1'b0);
		rdc(`AIS_IDX_STATUS, 32'h0000_0000);
		rdc(8'h30, 32'h0000_0000);
		chk(e, 1'b1);
		wr(`AIS_IDX_RES_LOW, 32'h0000_00FF);
		rdc(`AIS_IDX_RES_LOW, 32'h0000_0040);
		endSim();
	end
endmodule
